// File: logic/sscf_regs.vh
`ifndef SSCF_REGS_VH
`define SSCF_REGS_VH

// live spi format field positions and reset value
`define SSCF_CFG_W        8
`define SSCF_CFG_POL      0
`define SSCF_CFG_PHA      1
`define SSCF_CFG_SSP      2
`define SSCF_CFG_RST      8'h00

// character framing
`define SSCF_BYTE_W       8
`define SSCF_BIT_W        3
`define SSCF_BIT_LAST     3'h7
`define SSCF_IDLE_FILL    8'h00

// oscillator warm-up count
`define SSCF_WARM_CYC     65536
`define SSCF_WARM_W       17

// master side figures, kept for reference by the decoder
`define SSCF_HW_UPD_ADDR  12'h900
`define SSCF_SCLK_DIV     4
`define SSCF_GAP_CLKS     400

// receive buffer
`define SSCF_FIFO_DEPTH   4
`define SSCF_FIFO_AW      2
`endif

// File: logic/sscf_spi_slave.v
`include "sscf_regs.vh"

// small receive fifo, registered storage, honest full/empty
module sscf_fifo #(
   parameter W     = `SSCF_BYTE_W,
   parameter DEPTH = `SSCF_FIFO_DEPTH,
   parameter AW    = `SSCF_FIFO_AW
) (
   // clock and reset
   input  wire          clk_in,
   input  wire          srst_in,
   // fill side
   input  wire [W-1:0]  in_data_in,
   input  wire          in_valid_in,
   output wire          in_ready_out,
   // drain side
   output wire [W-1:0]  out_data_out,
   output wire          out_valid_out,
   input  wire          out_ready_in
);
   // integer forms first, then cut to pointer width on purpose
   localparam integer  FULL_I = DEPTH;
   localparam integer  LAST_I = DEPTH - 1;
   localparam [AW:0]   FULL = FULL_I[AW:0];
   localparam [AW-1:0] LAST = LAST_I[AW-1:0];

   reg  [W-1:0]  mem [0:DEPTH-1];
   reg  [AW-1:0] wr_r;
   reg  [AW-1:0] rd_r;
   reg  [AW:0]   cnt_r;
   wire          push;
   wire          pop;

   // handshakes on both sides
   assign in_ready_out  = (cnt_r != FULL);
   assign out_valid_out = (cnt_r != {(AW+1){1'b0}});
   assign out_data_out  = mem[rd_r];
   assign push          = in_valid_in & in_ready_out;
   assign pop           = out_valid_out & out_ready_in;

   // storage write, no reset needed on data
   always @(posedge clk_in) begin
      if (push) begin
         mem[wr_r] <= in_data_in;
      end
   end

   // pointers wrap explicitly so depth need not be a power of two
   always @(posedge clk_in) begin
      if (srst_in) begin
         wr_r  <= {AW{1'b0}};
         rd_r  <= {AW{1'b0}};
         cnt_r <= {(AW+1){1'b0}};
      end else begin
         if (push) begin
            wr_r <= (wr_r == LAST) ? {AW{1'b0}} : wr_r + 1'b1;
         end
         if (pop) begin
            rd_r <= (rd_r == LAST) ? {AW{1'b0}} : rd_r + 1'b1;
         end
         if (push & ~pop) begin
            cnt_r <= cnt_r + 1'b1;
         end else if (pop & ~push) begin
            cnt_r <= cnt_r - 1'b1;
         end
      end
   end
endmodule // sscf_fifo

// spi slave port with format control and clock source selection
module sscf_spi_slave #(
   parameter WARM_CYCLES = `SSCF_WARM_CYC,
   parameter WARM_W      = `SSCF_WARM_W,
   parameter FIFO_DEPTH  = `SSCF_FIFO_DEPTH,
   parameter FIFO_AW     = `SSCF_FIFO_AW
) (
   // clock and resets
   input  wire                   clk_in,
   input  wire                   srst_in,
   input  wire                   por_in,
   // spi pins
   input  wire                   sclk_in,
   input  wire                   ssel_in,
   input  wire                   mosi_in,
   output wire                   miso_out,
   output wire                   miso_oe_out,
   // interrupt request
   input  wire                   irq_pend_in,
   output wire                   irq_n_out,
   // configuration from register decoder
   input  wire [`SSCF_CFG_W-1:0] spi_format_config_in,
   input  wire                   ext_clk_mirror_in,
   input  wire                   hw_update_command_in,
   output wire [`SSCF_CFG_W-1:0] spi_format_config_out,
   output wire                   external_clock_select_out,
   output wire                   xtal_osc_en_out,
   // clock source
   input  wire                   oscillator_input_pin_in,
   input  wire                   low_power_mode_in,
   input  wire                   stop_exit_in,
   output wire                   hf_clk_sel_out,
   output wire                   warm_done_out,
   // transmit bytes
   input  wire [`SSCF_BYTE_W-1:0] tx_data_in,
   input  wire                   tx_valid_in,
   output wire                   tx_ready_out,
   // receive bytes
   output wire [`SSCF_BYTE_W-1:0] rx_data_out,
   output wire                   rx_valid_out,
   input  wire                   rx_ready_in,
   output wire                   rx_overrun_out,
   input  wire                   rx_overrun_clr_in,
   output wire                   byte_done_out
);
   localparam integer      WARM_LAST_I = WARM_CYCLES - 1;
   localparam [WARM_W-1:0] WARM_LAST = WARM_LAST_I[WARM_W-1:0];

   // synchronisers and edge history
   reg                     sclk_m_r, sclk_s_r, sclk_d_r;
   reg                     ssel_m_r, ssel_s_r, ssel_d_r;
   reg                     mosi_m_r, mosi_s_r;
   reg                     hf_m_r, hf_s_r, hf_d_r;
   // configuration
   reg  [`SSCF_CFG_W-1:0]  cfg_r;
   reg                     ext_clk_r;
   reg                     xosc_en_r;
   // shifter
   reg  [`SSCF_BYTE_W-1:0] tx_sh_r;
   reg  [`SSCF_BYTE_W-1:0] rx_sh_r;
   reg  [`SSCF_BYTE_W-1:0] rx_byte_r;
   reg  [`SSCF_BIT_W-1:0]  bit_cnt_r;
   reg                     armed_r;
   reg                     oe_r;
   reg                     done_r;
   reg                     tx_rdy_r;
   reg                     ovr_r;
   // clocking
   reg  [WARM_W-1:0]       warm_cnt_r;
   reg                     warm_done_r;
   reg                     hf_sel_r;
   reg                     irq_n_r;
   // output stage
   reg  [`SSCF_BYTE_W-1:0] rx_data_r;
   reg                     rx_valid_r;

   wire                    rst;
   wire                    pol, pha, ssp;
   wire                    ck_now, ck_prev;
   wire                    sel_now, sel_prev, sel_rise;
   wire                    act_edge, inact_edge;
   wire                    samp_edge, shft_edge;
   wire [`SSCF_BYTE_W-1:0] tx_next;
   wire [`SSCF_BYTE_W-1:0] rx_next;
   wire                    f_in_rdy;
   wire [`SSCF_BYTE_W-1:0] f_data;
   wire                    f_valid;
   wire                    f_pop;

   // power-on also counts as a system reset
   assign rst = srst_in | por_in;

   // live format fields
   assign pol = cfg_r[`SSCF_CFG_POL];
   assign pha = cfg_r[`SSCF_CFG_PHA];
   assign ssp = cfg_r[`SSCF_CFG_SSP];

   // pin synchronisers, first stage feeds only the second
   always @(posedge clk_in) begin
      sclk_m_r <= sclk_in;
      sclk_s_r <= sclk_m_r;
      sclk_d_r <= sclk_s_r;
      ssel_m_r <= ssel_in;
      ssel_s_r <= ssel_m_r;
      ssel_d_r <= ssel_s_r;
      mosi_m_r <= mosi_in;
      mosi_s_r <= mosi_m_r;
      hf_m_r   <= oscillator_input_pin_in;
      hf_s_r   <= hf_m_r;
      hf_d_r   <= hf_s_r;
   end

   // clock normalised so active edge is always a rise
   assign ck_now   = sclk_s_r ^ pol;
   assign ck_prev  = sclk_d_r ^ pol;
   // select polarity bit zero means active low
   assign sel_now  = ssel_s_r ^ ~ssp;
   assign sel_prev = ssel_d_r ^ ~ssp;
   assign sel_rise = sel_now & ~sel_prev;

   assign act_edge   = sel_now & ck_now & ~ck_prev;
   assign inact_edge = sel_now & ~ck_now & ck_prev;
   // phase picks which edge samples, the other one shifts
   assign samp_edge  = pha ? inact_edge : act_edge;
   assign shft_edge  = pha ? act_edge : inact_edge;

   // filler byte when nothing is queued, the master owns timing
   assign tx_next = tx_valid_in ? tx_data_in : `SSCF_IDLE_FILL;
   assign rx_next = {rx_sh_r[`SSCF_BYTE_W-2:0], mosi_s_r};

   // byte engine, transfers only ever begin on master activity
   always @(posedge clk_in) begin
      if (rst) begin
         tx_sh_r   <= `SSCF_IDLE_FILL;
         rx_sh_r   <= {`SSCF_BYTE_W{1'b0}};
         rx_byte_r <= {`SSCF_BYTE_W{1'b0}};
         bit_cnt_r <= {`SSCF_BIT_W{1'b0}};
         armed_r   <= 1'b0;
         oe_r      <= 1'b0;
         done_r    <= 1'b0;
         tx_rdy_r  <= 1'b0;
      end else begin
         done_r   <= 1'b0;
         tx_rdy_r <= 1'b0;
         if (!sel_now) begin
            bit_cnt_r <= {`SSCF_BIT_W{1'b0}};
            armed_r   <= 1'b0;
            oe_r      <= 1'b0;
         end else begin
            oe_r <= 1'b1;
            if (sel_rise & ~pha) begin
               // phase zero: first bit must be out before first edge
               tx_sh_r   <= tx_next;
               tx_rdy_r  <= tx_valid_in;
               armed_r   <= 1'b1;
               bit_cnt_r <= {`SSCF_BIT_W{1'b0}};
            end else begin
               if (shft_edge & (pha | armed_r)) begin
                  if (pha && bit_cnt_r == {`SSCF_BIT_W{1'b0}}) begin
                     tx_sh_r  <= tx_next;
                     tx_rdy_r <= tx_valid_in;
                  end else begin
                     // msb leaves first
                     tx_sh_r <= {tx_sh_r[`SSCF_BYTE_W-2:0], 1'b0};
                  end
               end
               if (samp_edge & (pha | armed_r)) begin
                  rx_sh_r   <= rx_next;
                  bit_cnt_r <= bit_cnt_r + 1'b1;
                  if (bit_cnt_r == `SSCF_BIT_LAST) begin
                     rx_byte_r <= rx_next;
                     done_r    <= 1'b1;
                     // phase zero needs a fresh select for the next byte
                     armed_r   <= pha;
                  end
               end
            end
         end
      end
   end

   // live format loads only on the update command
   always @(posedge clk_in) begin
      if (rst) begin
         cfg_r <= `SSCF_CFG_RST;
      end else if (hw_update_command_in) begin
         cfg_r <= spi_format_config_in;
      end
   end

   // external clock bit survives every reset but power-on
   always @(posedge clk_in) begin
      if (por_in) begin
         ext_clk_r <= 1'b0;
         xosc_en_r <= 1'b1;
      end else if (hw_update_command_in & ~srst_in) begin
         // an update is never taken while any reset is held
         ext_clk_r <= ext_clk_mirror_in;
         xosc_en_r <= ~ext_clk_mirror_in;
      end
   end

   // warm-up counts oscillator rises; restarts on stop exit
   always @(posedge clk_in) begin
      if (rst | stop_exit_in) begin
         warm_cnt_r  <= {WARM_W{1'b0}};
         warm_done_r <= 1'b0;
      end else if (hf_s_r & ~hf_d_r & ~warm_done_r) begin
         // a grounded pin never gets here, so warm-up never ends
         warm_cnt_r <= warm_cnt_r + 1'b1;
         if (warm_cnt_r == WARM_LAST) begin
            warm_done_r <= 1'b1;
         end
      end
   end

   // clock source choice and interrupt line
   always @(posedge clk_in) begin
      if (rst | stop_exit_in) begin
         hf_sel_r <= 1'b0;
      end else begin
         hf_sel_r <= warm_done_r & ~low_power_mode_in;
      end
   end

   always @(posedge clk_in) begin
      if (rst) begin
         irq_n_r <= 1'b1;
      end else begin
         irq_n_r <= ~irq_pend_in;
      end
   end

   // overrun: the master cannot be stalled, so a full buffer
   // drops the byte and flags it; a new drop beats the clear
   always @(posedge clk_in) begin
      if (rst) begin
         ovr_r <= 1'b0;
      end else if (done_r & ~f_in_rdy) begin
         ovr_r <= 1'b1;
      end else if (rx_overrun_clr_in) begin
         ovr_r <= 1'b0;
      end
   end

   // received bytes buffered ahead of the register decoder
   sscf_fifo #(
      .W     (`SSCF_BYTE_W),
      .DEPTH (FIFO_DEPTH),
      .AW    (FIFO_AW)
   ) u_rx_fifo (
      .clk_in        (clk_in),
      .srst_in       (rst),
      .in_data_in    (rx_byte_r),
      .in_valid_in   (done_r),
      .in_ready_out  (f_in_rdy),
      .out_data_out  (f_data),
      .out_valid_out (f_valid),
      .out_ready_in  (f_pop)
   );

   // output register stage keeps rx ports flop driven
   assign f_pop = f_valid & (~rx_valid_r | rx_ready_in);

   always @(posedge clk_in) begin
      if (rst) begin
         rx_valid_r <= 1'b0;
         rx_data_r  <= {`SSCF_BYTE_W{1'b0}};
      end else if (f_pop) begin
         rx_valid_r <= 1'b1;
         rx_data_r  <= f_data;
      end else if (rx_ready_in) begin
         rx_valid_r <= 1'b0;
      end
   end

   // outputs
   assign miso_out                  = tx_sh_r[`SSCF_BYTE_W-1];
   assign miso_oe_out               = oe_r;
   assign irq_n_out                 = irq_n_r;
   assign spi_format_config_out     = cfg_r;
   assign external_clock_select_out = ext_clk_r;
   assign xtal_osc_en_out           = xosc_en_r;
   assign hf_clk_sel_out            = hf_sel_r;
   assign warm_done_out             = warm_done_r;
   assign tx_ready_out              = tx_rdy_r;
   assign rx_data_out               = rx_data_r;
   assign rx_valid_out              = rx_valid_r;
   assign rx_overrun_out            = ovr_r;
   assign byte_done_out             = done_r;
endmodule // sscf_spi_slave

// File: bench/sscf_spi_slave_assertions.sv
// watches the slave port's pins and its clock source outputs
module sscf_spi_slave_assertions (
   // clock and resets
   input logic       clk_in,
   input logic       srst_in,
   input logic       por_in,
   // pins and interrupt
   input logic       ssel_in,
   input logic       miso_oe_out,
   input logic       irq_pend_in,
   input logic       irq_n_out,
   // format and clock control
   input logic [7:0] spi_format_config_in,
   input logic       ext_clk_mirror_in,
   input logic       hw_update_command_in,
   input logic [7:0] spi_format_config_out,
   input logic       external_clock_select_out,
   input logic       xtal_osc_en_out,
   input logic       low_power_mode_in,
   input logic       stop_exit_in,
   input logic       hf_clk_sel_out,
   input logic       warm_done_out,
   // receive side
   input logic       rx_valid_out,
   input logic       byte_done_out
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking @(posedge clk_in); endclocking
   default disable iff (srst_in || por_in);

   // warm-up just finished with nothing holding the slow clock
   sequence s_warm;
      $rose(warm_done_out) && !low_power_mode_in && !stop_exit_in;
   endsequence
   // select pin steadily inactive for the live polarity
   sequence s_idle;
      (ssel_in != spi_format_config_out[2]) [*6];
   endsequence

   a_update_loads: assert property (hw_update_command_in |=>
      spi_format_config_out == $past(spi_format_config_in) && external_clock_select_out == $past(ext_clk_mirror_in))
      else $error("live format not loaded by update");
   a_cfg_holds: assert property (!hw_update_command_in |=> $stable(spi_format_config_out))
      else $error("live format changed without update");
   // a plain system reset must leave the clock bit alone
   a_ext_only_por: assert property (disable iff (por_in) srst_in |=> $stable(external_clock_select_out))
      else $error("external clock bit lost on system reset");
   a_xtal_off: assert property (xtal_osc_en_out != external_clock_select_out)
      else $error("crystal enable does not follow clock bit");
   a_irq_level: assert property (1'b1 |=> irq_n_out != $past(irq_pend_in))
      else $error("interrupt line wrong");
   a_lp_internal: assert property (low_power_mode_in [*2] |-> !hf_clk_sel_out)
      else $error("fast clock used in low power");
   a_warm_first: assert property (!warm_done_out && !$past(warm_done_out) |-> !hf_clk_sel_out)
      else $error("fast clock before warm-up");
   a_warm_switch: assert property (s_warm |-> ##[0:2] hf_clk_sel_out)
      else $error("no switch after warm-up");
   a_done_pulse: assert property (byte_done_out |=> !byte_done_out [*8])
      else $error("byte done too often");
   a_done_queued: assert property (byte_done_out |-> ##[1:3] rx_valid_out)
      else $error("received byte not offered");
   a_idle_quiet: assert property (s_idle |-> !miso_oe_out)
      else $error("data out driven while deselected");
endmodule // sscf_spi_slave_assertions

// File: bench/sscf_spi_master_model.sv
// behavioural master; it alone opens every byte
module sscf_spi_master_model (
   // spi pins toward the slave
   output logic sclk_out,
   output logic ssel_n_out,
   output logic mosi_out,
   input  logic miso_in
);
   timeunit 1ns;
   timeprecision 100ps;
   localparam int HALF = 24;   // 48 ns link, well under a quarter of the slave clock
   localparam int GAP  = 2000; // 400 slave clocks of rest after every byte

   initial begin
      sclk_out = 1'b0;
      ssel_n_out = 1'b1;
      mosi_out = 1'b0;
   end

   // one byte each way, msb first
   task automatic xfer(input logic pol, input logic pha, input logic hold, input logic [7:0] d,
                       output logic [7:0] q);
      if (ssel_n_out) begin
         sclk_out = pol;        // idle level settles before select
         #(2*HALF);
         ssel_n_out = 1'b0;     // byte opens with select
         #(2*HALF);
      end
      for (int i = 7; i >= 0; i--) begin
         if (pha) begin
            sclk_out = ~pol;    // active edge opens the next bit
            mosi_out = d[i];
            #HALF;
            sclk_out = pol;
            q[i] = miso_in;     // taken on the return edge
            #HALF;
         end else begin
            mosi_out = d[i];
            #HALF;
            sclk_out = ~pol;
            q[i] = miso_in;
            #HALF;
            sclk_out = pol;
         end
      end
      #HALF;
      mosi_out = ~mosi_out;     // no stale bit left on the line
      if (!hold)
         ssel_n_out = 1'b1;
      #GAP;
   endtask
endmodule // sscf_spi_master_model

// File: bench/tb_sscf_spi_slave.sv
module tb_sscf_spi_slave;
   timeunit 1ns;
   timeprecision 100ps;
   logic       clk_in, srst_in, por_in, irq_pend_in, ext_clk_mirror_in, hw_update_command_in;
   logic       oscillator_input_pin_in, low_power_mode_in, stop_exit_in, tx_valid_in, rx_ready_in;
   logic       rx_overrun_clr_in;
   logic [7:0] spi_format_config_in, tx_data_in, got, exp_q[6];
   logic [1:0] mode;
   wire        sclk_in, ssel_in, mosi_in, miso_out, miso_oe_out, irq_n_out, external_clock_select_out;
   wire        xtal_osc_en_out, hf_clk_sel_out, warm_done_out, tx_ready_out, rx_valid_out;
   wire        rx_overrun_out, byte_done_out, miso_w;
   wire [7:0]  spi_format_config_out, rx_data_out;
   int         errors, num_checks;
   int         tx_takes;

   // released data line shows the inverse, never a stale level
   assign miso_w = miso_oe_out ? miso_out : ~miso_out;

   // count transmit bytes the slave reports as taken
   always @(posedge clk_in) begin
      if (tx_ready_out === 1'b1)
         tx_takes <= tx_takes + 1;
   end

   sscf_spi_slave #(.WARM_CYCLES(8)) dut (.clk_in, .srst_in, .por_in, .sclk_in, .ssel_in, .mosi_in,
      .miso_out, .miso_oe_out, .irq_pend_in, .irq_n_out, .spi_format_config_in, .ext_clk_mirror_in,
      .hw_update_command_in, .spi_format_config_out, .external_clock_select_out, .xtal_osc_en_out,
      .oscillator_input_pin_in, .low_power_mode_in, .stop_exit_in, .hf_clk_sel_out, .warm_done_out,
      .tx_data_in, .tx_valid_in, .tx_ready_out, .rx_data_out, .rx_valid_out, .rx_ready_in,
      .rx_overrun_out, .rx_overrun_clr_in, .byte_done_out);
   sscf_spi_master_model master (.sclk_out(sclk_in), .ssel_n_out(ssel_in), .mosi_out(mosi_in),
      .miso_in(miso_w));

   initial begin
      clk_in = 1'b0;
      forever #2.5 clk_in = ~clk_in;
   end

   task automatic give_verdict;
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] seen);
      num_checks++;
      if (seen !== exp) begin
         errors++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // sample a little after the edge so its updates have landed
   task automatic tick(input int n);
      repeat (n) @(posedge clk_in);
      #1;
   endtask
   task automatic upd(input logic [7:0] cfg, input logic ext);
      @(posedge clk_in);
      spi_format_config_in <= cfg;
      ext_clk_mirror_in <= ext;
      hw_update_command_in <= 1'b1;
      @(posedge clk_in);
      hw_update_command_in <= 1'b0;
      tick(2);
   endtask
   // bounded wait for a queued byte, then take it
   task automatic pop(input logic [7:0] exp);
      int n;
      n = 0;
      while (rx_valid_out !== 1'b1 && n < 50) begin
         tick(1);
         n++;
      end
      if (n == 50) begin
         errors++;
         give_verdict();
      end
      chk("rx byte", exp, rx_data_out);
      rx_ready_in <= 1'b1;
      tick(1);
      rx_ready_in <= 1'b0;
      tick(1);
   endtask

   initial begin
      {irq_pend_in, ext_clk_mirror_in, hw_update_command_in, oscillator_input_pin_in} = 4'h0;
      {low_power_mode_in, stop_exit_in, tx_valid_in, rx_ready_in, rx_overrun_clr_in} = 5'h00;
      {spi_format_config_in, tx_data_in} = 16'h0000;
      {srst_in, por_in} = 2'h3;
      tick(12);
      {srst_in, por_in} <= 2'h0;
      tick(3);
      chk("format", 8'h00, spi_format_config_out);
      chk("ext clock", 8'h00, {7'h0, external_clock_select_out});
      tick(20);
      chk("hf select", 8'h00, {7'h0, hf_clk_sel_out});
      repeat (8) begin
         oscillator_input_pin_in <= 1'b1;
         tick(3);
         oscillator_input_pin_in <= 1'b0;
         tick(3);
      end
      tick(6);
      chk("hf select", 8'h01, {7'h0, hf_clk_sel_out});
      low_power_mode_in <= 1'b1;
      tick(3);
      chk("hf select", 8'h00, {7'h0, hf_clk_sel_out});
      low_power_mode_in <= 1'b0;
      stop_exit_in <= 1'b1;
      tick(1);
      stop_exit_in <= 1'b0;
      tick(3);
      chk("hf select", 8'h00, {7'h0, hf_clk_sel_out});
      irq_pend_in <= 1'b1;
      tick(2);
      chk("irq", 8'h00, {7'h0, irq_n_out});
      irq_pend_in <= 1'b0;
      // four formats, then two held-select bytes; nothing drained so the buffer overflows
      for (int k = 0; k < 6; k++) begin
         mode = (k < 4) ? k[1:0] : 2'h3;
         if (k < 4)
            upd({6'h00, mode}, 1'b0);
         exp_q[k] = 8'hc5 + 8'h13 * k[7:0];
         tx_data_in <= ~exp_q[k];
         tx_valid_in <= 1'b1;
         tick(1);
         master.xfer(mode[0], mode[1], k == 4, exp_q[k], got);
         chk("miso byte", ~exp_q[k], got);
      end
      chk("tx takes", 8'h06, tx_takes[7:0]);
      chk("overrun", 8'h01, {7'h0, rx_overrun_out});
      rx_overrun_clr_in <= 1'b1;
      tick(1);
      rx_overrun_clr_in <= 1'b0;
      tick(2);
      chk("overrun", 8'h00, {7'h0, rx_overrun_out});
      for (int k = 0; k < 5; k++)
         pop(exp_q[k]);
      upd(8'h03, 1'b1);
      chk("xtal enable", 8'h00, {7'h0, xtal_osc_en_out});
      srst_in <= 1'b1;
      tick(2);
      srst_in <= 1'b0;
      tick(1);
      chk("ext clock", 8'h01, {7'h0, external_clock_select_out});
      chk("format", 8'h00, spi_format_config_out);
      por_in <= 1'b1;
      tick(2);
      por_in <= 1'b0;
      tick(1);
      chk("ext clock", 8'h00, {7'h0, external_clock_select_out});
      give_verdict();
   end

   // hang guard
   initial begin
      #400000;
      errors++;
      give_verdict();
   end
endmodule // tb_sscf_spi_slave

bind sscf_spi_slave sscf_spi_slave_assertions chk_i (.clk_in, .srst_in, .por_in, .ssel_in, .miso_oe_out,
   .irq_pend_in, .irq_n_out, .spi_format_config_in, .ext_clk_mirror_in, .hw_update_command_in,
   .spi_format_config_out, .external_clock_select_out, .xtal_osc_en_out, .low_power_mode_in,
   .stop_exit_in, .hf_clk_sel_out, .warm_done_out, .rx_valid_out, .byte_done_out);
